// File: design/keypad_pkg.sv
// Package of register offsets, reset values and widths for the keypad interrupt unit.
package keypad_pkg;
	localparam int        LINE_COUNT       = 8;
	localparam int        ADDR_WIDTH       = 8;
	localparam int        DATA_WIDTH       = 8;
	localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h9C;
	localparam logic [7:0] ADDR_LINE_ENABLE  = 8'h9D;
	localparam logic [7:0] ADDR_LINE_FLAGS   = 8'h9E;
	localparam logic [7:0] RESET_LEVEL_SELECT = 8'h00;
	localparam logic [7:0] RESET_LINE_ENABLE  = 8'h00;
	localparam logic [7:0] RESET_LINE_FLAGS   = 8'h00;
	localparam logic [7:0] READ_IDLE_VALUE    = 8'h00;
endpackage : keypad_pkg

// File: design/key_level_detect.sv
// Per-line level detector that compares each port line with its selected level.
`timescale 1ns/1ps
module key_level_detect
	import keypad_pkg::*;
(
	// Port lines and level choice.
	input  wire logic [LINE_COUNT-1:0] port_one,
	input  wire logic [LINE_COUNT-1:0] key_level_select,
	// Lines that show their chosen level.
	output logic      [LINE_COUNT-1:0] hit
);
	// A set select bit looks for high, a clear bit for low.
	assign hit = ~(port_one ^ key_level_select);
endmodule : key_level_detect

// File: design/key_flag_bank.sv
// Flag bank: level hits set flags, a read of the flag register clears them.
`timescale 1ns/1ps
module key_flag_bank
	import keypad_pkg::*;
(
	// Clock and synchronised reset.
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Hits and the clear strobe.
	input  wire logic [LINE_COUNT-1:0] hit,
	input  wire logic                  clear_all,
	// Flag state.
	output logic      [LINE_COUNT-1:0] flags
);
	logic [LINE_COUNT-1:0] next_flags;

	// A hit in the clearing cycle survives, so no level is lost to a read.
	always_comb begin
		next_flags = (clear_all ? '0 : flags) | hit;
	end

	// Flags start clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= RESET_LINE_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end
endmodule : key_flag_bank

// File: design/keypad_level_interrupt.sv
// Top of the keypad level interrupt unit with its special function registers.
`timescale 1ns/1ps
module keypad_level_interrupt
	import keypad_pkg::*;
(
	// Clock and reset.
	input  wire logic                          CLK_SYS,
	input  wire logic                          RESET_N,
	// Port one lines.
	input  wire logic [keypad_pkg::LINE_COUNT-1:0] PORT_ONE,
	// Global keyboard enable from the core's second interrupt enable register.
	input  wire logic                          KEY_GLOBAL_IRQ_ENABLE,
	// Special function register access.
	input  wire logic [keypad_pkg::ADDR_WIDTH-1:0] SFR_ADDR,
	input  wire logic                          SFR_WRITE,
	input  wire logic                          SFR_READ,
	input  wire logic [keypad_pkg::DATA_WIDTH-1:0] SFR_WDATA,
	output logic      [keypad_pkg::DATA_WIDTH-1:0] SFR_RDATA,
	// Requests toward the core.
	output logic                               KEY_IRQ,
	output logic                               KEY_WAKE,
	output logic      [keypad_pkg::LINE_COUNT-1:0] KEY_LINE_ALT
);
	import keypad_pkg::*;

	// Synchronised reset and the three register copies.
	logic                  rst_meta;
	logic                  rst_n;
	logic [LINE_COUNT-1:0] key_level_select;
	logic [LINE_COUNT-1:0] key_line_enable;
	logic [LINE_COUNT-1:0] key_line_flags;
	logic [LINE_COUNT-1:0] hit;
	logic                  flag_read;
	logic                  pending;

	// Reset is released through two flops so every process leaves reset together.
	// Only the second flop reads rst_meta, which may still be settling.
	// Assertion stays asynchronous, so a stopped clock cannot keep stale register values.
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Register decode: a read of the flag address is the clear strobe.
	// A read strobe held for several cycles clears the flags on every one of them.
	// Software must therefore only read the flag register when it means to retire flags.
	assign flag_read = SFR_READ && (SFR_ADDR == ADDR_LINE_FLAGS);

	// Writable level select and enable registers; the flag address ignores writes.
	// Writes to unmapped addresses fall through and change nothing.
	// The registers keep their values until software rewrites them or reset clears them.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			key_level_select <= RESET_LEVEL_SELECT;
			key_line_enable  <= RESET_LINE_ENABLE;
		end else if (SFR_WRITE) begin
			if (SFR_ADDR == ADDR_LEVEL_SELECT) begin
				key_level_select <= SFR_WDATA;
			end else if (SFR_ADDR == ADDR_LINE_ENABLE) begin
				key_line_enable <= SFR_WDATA;
			end
		end
	end

	// Level comparison for all eight lines.
	// No synchroniser sits here, because the port lines are taken as synchronous.
	// A bouncing switch sets its flag on the first sample at the chosen level.
	key_level_detect u_detect (
		.port_one         (PORT_ONE),
		.key_level_select (key_level_select),
		.hit              (hit)
	);

	// Flag storage with read-to-clear.
	// Flags are set for every line, enabled or not, so software can poll masked lines.
	key_flag_bank u_flags (
		.clk       (CLK_SYS),
		.rst_n     (rst_n),
		.hit       (hit),
		.clear_all (flag_read),
		.flags     (key_line_flags)
	);

	// Masked sources merged into one request.
	// A line with a clear enable bit keeps its flag; only its request is masked.
	assign pending = |(key_line_flags & key_line_enable);

	// Read data is registered; unmapped addresses read as zero.
	// The flags are captured on the same edge that clears them, so a read never
	// loses a flag that it has not also reported.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			SFR_RDATA <= READ_IDLE_VALUE;
		end else if (SFR_READ) begin
			if (SFR_ADDR == ADDR_LEVEL_SELECT) begin
				SFR_RDATA <= key_level_select;
			end else if (SFR_ADDR == ADDR_LINE_ENABLE) begin
				SFR_RDATA <= key_line_enable;
			end else if (SFR_ADDR == ADDR_LINE_FLAGS) begin
				SFR_RDATA <= key_line_flags;
			end else begin
				SFR_RDATA <= READ_IDLE_VALUE;
			end
		end
	end

	// Request, wake and alternate-function outputs, all from flops.
	// Wake ignores the global enable on purpose: a masked-off core still needs waking.
	// Registering every output costs one cycle from flag to request.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			KEY_IRQ      <= 1'b0;
			KEY_WAKE     <= 1'b0;
			KEY_LINE_ALT <= '0;
		end else begin
			KEY_IRQ      <= pending && KEY_GLOBAL_IRQ_ENABLE;
			KEY_WAKE     <= pending;
			KEY_LINE_ALT <= key_line_enable;
		end
	end

	// Checks on the register map, the flags and the request outputs.
	// They watch internal state as well as pins, so they sit beside the logic.

	// Request follows flags and enables one cycle later.
	chk_irq_follows_flags: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		1'b1 |=> KEY_IRQ == ($past(pending) && $past(KEY_GLOBAL_IRQ_ENABLE)))
		else $error("keyboard request does not match masked flags");

	// A held level keeps its flag set even across a read.
	chk_flag_level_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		hit[0] |=> key_line_flags[0])
		else $error("line zero flag not set by its level");

	// A read with no hit leaves the flags clear.
	chk_read_clears_all: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(flag_read && hit == '0) |=> key_line_flags == '0)
		else $error("flag read did not clear flags");

	// Line one's flag never sets without a hit.
	chk_flag_needs_hit: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(key_line_flags[1] && !$past(key_line_flags[1])) |-> $past(hit[1]))
		else $error("flag set without detection");

	// High select means a high line hits.
	chk_level_polarity: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		hit[2] == (PORT_ONE[2] == key_level_select[2]))
		else $error("level polarity wrong");

	// Writes to the enable register land.
	chk_enable_write: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_WRITE && SFR_ADDR == ADDR_LINE_ENABLE) |=> key_line_enable == $past(SFR_WDATA))
		else $error("enable register write lost");

	// Wake tracks enabled flags regardless of the global enable.
	chk_wake_enabled: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		pending |=> KEY_WAKE)
		else $error("wake missing for enabled flag");

	// Alternate-function view follows the enable register.
	chk_alt_follows: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		1'b1 |=> KEY_LINE_ALT == $past(key_line_enable))
		else $error("alternate function mismatch");

	// Registers hold zero when reset is released.
	chk_reset_zero: assert property (@(posedge CLK_SYS)
		$rose(rst_n) |-> (key_line_enable == '0 && key_level_select == '0))
		else $error("registers not zero after reset");

	// Every line that shows its level has its flag set at the next edge.
	chk_flags_follow_hits: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(hit != '0) |=> ((key_line_flags & $past(hit)) == $past(hit)))
		else $error("a line at its level left its flag clear");

	// No flag rises unless its line showed the level one cycle earlier.
	chk_flag_origin: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		1'b1 |-> ((key_line_flags & ~$past(key_line_flags) & ~$past(hit)) == '0))
		else $error("a flag rose with no detection behind it");

	// Outside a flag read, flags only ever gain bits.
	chk_flags_sticky: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(!flag_read) |=>
		((key_line_flags & $past(key_line_flags)) == $past(key_line_flags)))
		else $error("a flag was lost without a read");

	// A flag read leaves set exactly the lines that still show their level.
	chk_read_rearms: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		flag_read |=> (key_line_flags == $past(hit)))
		else $error("flags after a read do not match the held levels");

	// Writes to the flag address change nothing in the flags.
	chk_flags_read_only: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_WRITE && SFR_ADDR == ADDR_LINE_FLAGS && !flag_read) |=>
		(key_line_flags == ($past(key_line_flags) | $past(hit))))
		else $error("a write reached the flag register");

	// A flag read returns the flags as they stood before the clear.
	chk_read_flag_data: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		flag_read |=> (SFR_RDATA == $past(key_line_flags)))
		else $error("flag read returned wrong data");

	// A read of the level select address returns that register.
	chk_read_select_data: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_READ && SFR_ADDR == ADDR_LEVEL_SELECT) |=>
		(SFR_RDATA == $past(key_level_select)))
		else $error("level select read returned wrong data");

	// A read of the enable address returns that register.
	chk_read_enable_data: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_READ && SFR_ADDR == ADDR_LINE_ENABLE) |=>
		(SFR_RDATA == $past(key_line_enable)))
		else $error("enable read returned wrong data");

	// Addresses outside the map read as the idle value.
	chk_read_unmapped: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_READ && SFR_ADDR != ADDR_LEVEL_SELECT && SFR_ADDR != ADDR_LINE_ENABLE &&
		SFR_ADDR != ADDR_LINE_FLAGS) |=> (SFR_RDATA == READ_IDLE_VALUE))
		else $error("unmapped read returned data");

	// Read data stands until the next read.
	chk_rdata_holds: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(!SFR_READ) |=> $stable(SFR_RDATA))
		else $error("read data changed without a read");

	// Writes to the level select register land.
	chk_select_write: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_WRITE && SFR_ADDR == ADDR_LEVEL_SELECT) |=>
		(key_level_select == $past(SFR_WDATA)))
		else $error("level select write lost");

	// Without a write both writable registers keep their values.
	chk_regs_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(!SFR_WRITE) |=>
		($stable(key_level_select) && $stable(key_line_enable)))
		else $error("register changed without a write");

	// A write to the flag address leaves both writable registers alone.
	chk_flag_write_inert: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(SFR_WRITE && SFR_ADDR == ADDR_LINE_FLAGS) |=>
		($stable(key_level_select) && $stable(key_line_enable)))
		else $error("flag address write reached another register");

	// With every set flag masked the request stays low.
	chk_masked_quiet: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		((key_line_flags & key_line_enable) == '0) |=> !KEY_IRQ)
		else $error("request raised by masked flags");

	// The global enable blocks every keyboard source.
	chk_global_gate: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(!KEY_GLOBAL_IRQ_ENABLE) |=> !KEY_IRQ)
		else $error("request raised with the global enable clear");

	// A request always has an enabled flag behind it.
	chk_irq_has_source: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		KEY_IRQ |-> (($past(key_line_flags) & $past(key_line_enable)) != '0))
		else $error("request with no enabled flag");

	// With every set flag masked the wake request stays low.
	chk_wake_quiet: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		((key_line_flags & key_line_enable) == '0) |=> !KEY_WAKE)
		else $error("wake raised by masked flags");

	// A wake request always has an enabled flag behind it.
	chk_wake_has_source: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		KEY_WAKE |-> (($past(key_line_flags) & $past(key_line_enable)) != '0))
		else $error("wake with no enabled flag");

	// Wake still fires while the global enable holds the request back.
	chk_wake_ungated: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(pending && !KEY_GLOBAL_IRQ_ENABLE) |=> (KEY_WAKE && !KEY_IRQ))
		else $error("wake blocked by the global enable");

	// A clear select bit detects a low line.
	chk_low_level_hit: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(!key_level_select[1] && !PORT_ONE[1]) |-> hit[1])
		else $error("low level not detected");

	// A set select bit detects a high line.
	chk_high_level_hit: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(key_level_select[7] && PORT_ONE[7]) |-> hit[7])
		else $error("high level not detected");

	// Flags, requests and read data are clear when reset is released.
	chk_reset_outputs: assert property (@(posedge CLK_SYS)
		$rose(rst_n) |-> (key_line_flags == '0 && !KEY_IRQ && !KEY_WAKE &&
		SFR_RDATA == READ_IDLE_VALUE))
		else $error("flags or outputs not clear after reset");
endmodule : keypad_level_interrupt

// File: testbench/key_matrix.sv
// Model of matrix key switches that hang on the port one lines.
`timescale 1ns/1ps
module key_matrix (
	// Keys held down by the bench.
	input  wire logic [7:0] pressed,
	// Port one lines seen by the unit.
	output logic      [7:0] lines
);
	// A closed switch grounds its line; open lines rest high on the port pull-ups.
	assign lines = ~pressed;
endmodule : key_matrix

// File: testbench/test_keypad_level_interrupt.sv
// Self-checking testbench for the keypad level interrupt unit.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got %h expected %h", $time, g, e); end end
module test_keypad_level_interrupt;
	import keypad_pkg::*;
	logic       clk     = 1'b0;
	logic       rst_n   = 1'b0;
	logic       gie     = 1'b0;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic [7:0] addr    = 8'h00;
	logic [7:0] wdata   = 8'h00;
	logic [7:0] pressed = 8'h00;
	wire  [7:0] port;
	wire  [7:0] rdata;
	wire  [7:0] alt;
	wire        irq;
	wire        wake;
	int         fails      = 0;
	int         n_compared = 0;

	// Keys on the far side of port one.
	key_matrix keys (.pressed(pressed), .lines(port));

	keypad_level_interrupt uut (
		.CLK_SYS(clk), .RESET_N(rst_n), .PORT_ONE(port), .KEY_GLOBAL_IRQ_ENABLE(gie),
		.SFR_ADDR(addr), .SFR_WRITE(wr), .SFR_READ(rd), .SFR_WDATA(wdata),
		.SFR_RDATA(rdata), .KEY_IRQ(irq), .KEY_WAKE(wake), .KEY_LINE_ALT(alt));

	// Clock at 200 MHz.
	initial forever #2.5 clk = ~clk;

	// Waits n edges and steps off the edge so inputs never race it.
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cy

	// One-cycle write strobe; a gap edge keeps back-to-back calls race free.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		cy(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cy(1);
		wr = 1'b0;
	endtask : wr_reg

	// One-cycle read strobe, then the registered data is compared.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		cy(1);
		addr = a;
		rd = 1'b1;
		cy(1);
		rd = 1'b0;
		`CHK(rdata, e)
	endtask : rd_chk

	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Cuts a hang short; the tests need well under two thousand cycles.
	initial begin
		#20000;
		fails++;
		tally_and_finish();
	end

	// Register map, masking, clear on read and level choice.
	initial begin
		cy(8);
		rst_n = 1'b1;
		cy(3);
		rd_chk(ADDR_LEVEL_SELECT, 8'h00);
		rd_chk(ADDR_LINE_ENABLE, 8'h00);
		rd_chk(ADDR_LINE_FLAGS, 8'h00);
		wr_reg(ADDR_LINE_ENABLE, 8'hA5);
		wr_reg(ADDR_LINE_FLAGS, 8'hFF);
		rd_chk(ADDR_LINE_ENABLE, 8'hA5);
		`CHK(alt, 8'hA5)
		rd_chk(ADDR_LINE_FLAGS, 8'h00);
		rd_chk(8'h9F, 8'h00);
		gie = 1'b1;
		pressed = 8'h02;
		cy(3);
		`CHK(irq, 1'b0)
		pressed = 8'h00;
		rd_chk(ADDR_LINE_FLAGS, 8'h02);
		rd_chk(ADDR_LINE_FLAGS, 8'h00);
		pressed = 8'h01;
		cy(3);
		`CHK(irq, 1'b1)
		`CHK(wake, 1'b1)
		gie = 1'b0;
		cy(2);
		`CHK(irq, 1'b0)
		`CHK(wake, 1'b1)
		rd_chk(ADDR_LINE_FLAGS, 8'h01);
		rd_chk(ADDR_LINE_FLAGS, 8'h01);
		pressed = 8'h00;
		rd_chk(ADDR_LINE_FLAGS, 8'h01);
		rd_chk(ADDR_LINE_FLAGS, 8'h00);
		cy(2);
		`CHK(wake, 1'b0)
		wr_reg(ADDR_LEVEL_SELECT, 8'h80);
		cy(2);
		rd_chk(ADDR_LEVEL_SELECT, 8'h80);
		pressed = 8'h80;
		rd_chk(ADDR_LINE_FLAGS, 8'h80);
		rd_chk(ADDR_LINE_FLAGS, 8'h00);
		tally_and_finish();
	end
endmodule : test_keypad_level_interrupt
